// ### src/adc_encode_and_output_port.sv
// Digital timing side of a pipelined 12-bit sampling converter: encode sampling,
// pipeline, output coding, range flag, delayed output clock and output disable.
// Assumes the encode clock, format select and output enable arrive from pins
// asynchronous to sys_clk, and that sys_clk is many times faster than encode.
// The quantised front-end level arrives on the sys_clk domain.
//
// Function
// [R1] Source keeps encode at or below top rate
// [R2] At top rate duty within five percent
// [R3] Each encode phase at least minimum half-period
// [R4] Below top rate duty free, phases long
// [R5] Source keeps encode above lowest rate
// [R6] Format select high offset binary, low twos-complement
// [R7] Flag high when input outside full scale
// [R8] Output clock is delayed encode copy
// [R9] Data changes after output clock falls; capture rising
// [R10] Sine encode: capture uses output clock
// [R11] Enable low floats data, flag, output clock
// [R12] Enable not toggled during full-speed conversion
// [R13] Acquire on encode fall, hold on rise
// [R14] Twelve-bit word, pipeline latency a parameter
`timescale 1ns/100ps
module adc_encode_and_output_port #(
  parameter int PIPE_DEPTH = adc_port_pkg::PIPE_DEPTH_DEF
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic encode_clock_in,
  input wire logic code_format_select,
  input wire logic outputEnable_n,
  input wire logic signed [adc_port_pkg::LEVEL_W-1:0] analogLevel,
  output logic [adc_port_pkg::WORD_W-1:0] dataWord_r,
  output logic range_exceed_flag_r,
  output logic output_sync_clock_r,
  output logic driveEnable_r
);
  import adc_port_pkg::*;

  generate
    if (PIPE_DEPTH < 1) begin : g_bad_depth
      $error("PIPE_DEPTH must be at least 1");
    end
    // The synchroniser shifts below are written for exactly two stages
    if (SYNC_STAGES != 2) begin : g_bad_sync
      $error("SYNC_STAGES must be 2");
    end
    // The level needs headroom beyond the word to show out-of-range inputs
    if (LEVEL_W <= WORD_W) begin : g_bad_level
      $error("LEVEL_W must exceed WORD_W");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage 0 feeds only stage 1
  // Three edges from pin to output clock; encode phases shorter than one sys_clk period can be lost
  logic [SYNC_STAGES-1:0] encSync_r;
  logic [SYNC_STAGES-1:0] fmtSync_r;
  logic [SYNC_STAGES-1:0] oeSync_r;
  logic encPrev_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      encSync_r <= '0;
      fmtSync_r <= '0;
      oeSync_r <= '0;
      encPrev_r <= 1'b0;
    end else begin
      encSync_r <= {encSync_r[0], encode_clock_in};
      fmtSync_r <= {fmtSync_r[0], code_format_select};
      oeSync_r <= {oeSync_r[0], outputEnable_n};
      encPrev_r <= encSync_r[1];
    end
  end

  wire encNow = encSync_r[1];
  wire fmtNow = fmtSync_r[1];
  wire oeNow = oeSync_r[1];
  wire encRise = encNow & ~encPrev_r;
  wire encFall = ~encNow & encPrev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Quantiser: clamp to full scale and convert to offset binary
  function automatic logic beyond_scale(input logic signed [LEVEL_W-1:0] lvl);
    return (lvl > FS_MAX) || (lvl < FS_MIN);
  endfunction : beyond_scale

  function automatic sample_t quantise(input logic signed [LEVEL_W-1:0] lvl);
    sample_t s;
    s.rangeExceed = beyond_scale(lvl);
    if (lvl > FS_MAX) begin
      s.code = {WORD_W{1'b1}};
    end else if (lvl < FS_MIN) begin
      s.code = {WORD_W{1'b0}};
    end else begin
      s.code = lvl[WORD_W-1:0] ^ OFFSET_MID;
    end
    return s;
  endfunction : quantise

  wire sample_t heldSample = quantise(analogLevel); // see [R7]

  ////////////////////////////////////////////////////////////////////////////
  // Pipeline: one stage per encode cycle, loaded at the hold edge
  // Reset contents leave zero words on the port until the pipe fills, or 12'h800 words with format select low
  sample_t pipe_r [PIPE_DEPTH];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pipe_r[0] <= SAMPLE_RST;
    end else if (encRise) begin
      pipe_r[0] <= heldSample; // see [R13]
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < PIPE_DEPTH; gi++) begin : g_pipe
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          pipe_r[gi] <= SAMPLE_RST;
        end else if (encRise) begin
          pipe_r[gi] <= pipe_r[gi-1]; // see [R14]
        end
      end
    end
  endgenerate

  wire sample_t headSample = pipe_r[PIPE_DEPTH-1];
  // Two's complement differs from offset binary only in the top bit
  wire [WORD_W-1:0] codedWord = {headSample.code[WORD_W-1] ^ ~fmtNow, headSample.code[WORD_W-2:0]}; // see [R6]

  ////////////////////////////////////////////////////////////////////////////
  // Output stage. Data is launched on the same sys_clk edge where the
  // delayed clock falls, leaving a full low phase before the capture edge.
  // Format is applied at launch, so a change reaches only later words
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      output_sync_clock_r <= 1'b0;
      dataWord_r <= WORD_RST;
      range_exceed_flag_r <= 1'b0;
      driveEnable_r <= 1'b0;
    end else begin
      output_sync_clock_r <= encNow; // see [R8]
      driveEnable_r <= oeNow; // see [R11]
      if (encFall) begin
        dataWord_r <= codedWord; // see [R9]
        range_exceed_flag_r <= headSample.rangeExceed; // see [R7]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_format_msb: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R6]
    encFall |=> dataWord_r[WORD_W-1] == ($past(headSample.code[WORD_W-1]) ^ ~$past(fmtNow)))
    else $error("output word coding does not follow format select");

  a_flag_range: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R7]
    encRise |=> pipe_r[0].rangeExceed == ($past(analogLevel) > FS_MAX || $past(analogLevel) < FS_MIN))
    else $error("range flag does not match input level");

  a_clock_copy: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R8]
    ##1 output_sync_clock_r == $past(encSync_r[1]))
    else $error("output clock is not the delayed encode");

  a_data_change_edge: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R9]
    !$stable(dataWord_r) |-> $fell(output_sync_clock_r))
    else $error("data changed away from output clock fall");

  a_flag_stable: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R9]
    output_sync_clock_r && !encFall |=> $stable(range_exceed_flag_r))
    else $error("range flag changed while output clock high");

  a_hiz_all: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R11]
    !outputEnable_n [*3] |=> !driveEnable_r)
    else $error("outputs still driven while enable held low");

  a_hold_edge: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R13]
    !encRise |=> $stable(pipe_r[0]))
    else $error("sample captured away from encode rising edge");

  a_pipe_shift: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R14]
    encRise |=> pipe_r[PIPE_DEPTH-1] == $past(pipe_r[PIPE_DEPTH > 1 ? PIPE_DEPTH-2 : 0]) || PIPE_DEPTH == 1)
    else $error("pipeline did not advance one stage per encode");

  a_head_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R14]
    !encRise |=> $stable(pipe_r[PIPE_DEPTH-1]))
    else $error("pipeline head moved away from encode rising edge");

  a_word_low_bits: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R6]
    encFall |=> dataWord_r[WORD_W-2:0] == $past(headSample.code[WORD_W-2:0]))
    else $error("format changed more than the top bit");

  a_flag_out: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R7]
    encFall |=> range_exceed_flag_r == $past(headSample.rangeExceed))
    else $error("range flag does not follow its sample");

  a_quiet_between: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R9]
    !encFall |=> $stable(dataWord_r) && $stable(range_exceed_flag_r))
    else $error("output word or flag changed between launches");

  a_enable_return: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R11]
    outputEnable_n [*3] |=> driveEnable_r)
    else $error("outputs not driven again after enable returned");

  ////////////////////////////////////////////////////////////////////////////
  // Checks against the raw pins, three edges back; skipped just after reset
  a_format_pin: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R6]
    encFall |=> dataWord_r[WORD_W-1] == ($past(headSample.code[WORD_W-1]) ^ ~$past(code_format_select, 3)))
    else $error("output word coding does not follow the format pin");

  a_clock_pin: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R8]
    $past(resetn, 3) |-> output_sync_clock_r == $past(encode_clock_in, 3))
    else $error("output clock does not follow the encode pin");

  a_rise_from_pin: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R13]
    encRise && $past(resetn, 3) |-> $past(encode_clock_in, 2) && !$past(encode_clock_in, 3))
    else $error("hold edge seen without an encode rise on the pin");

  a_fall_from_pin: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R9]
    encFall && $past(resetn, 3) |-> !$past(encode_clock_in, 2) && $past(encode_clock_in, 3))
    else $error("launch seen without an encode fall on the pin");
endmodule : adc_encode_and_output_port

// ### src/adc_port_pkg.sv
// Shared constants and types for the converter output port.
// Assumes a single system clock domain; the encode, format and enable pins are synchronised inside the block.
package adc_port_pkg;
  localparam int WORD_W = 12;
  localparam int LEVEL_W = 14;
  localparam int PIPE_DEPTH_DEF = 5;
  localparam int SYNC_STAGES = 2;
  // Full scale in signed levels; beyond these the flag is raised
  localparam logic signed [LEVEL_W-1:0] FS_MAX = 14'sh07FF;
  localparam logic signed [LEVEL_W-1:0] FS_MIN = -14'sh0800;
  localparam logic [WORD_W-1:0] OFFSET_MID = 12'h0800;
  localparam logic [WORD_W-1:0] WORD_RST = 12'h0000;

  // One converted sample in offset binary plus its range flag
  typedef struct packed {
    logic rangeExceed;
    logic [WORD_W-1:0] code;
  } sample_t;

  localparam sample_t SAMPLE_RST = '{rangeExceed: 1'b0, code: WORD_RST};
endpackage : adc_port_pkg

// ### test/enc_source.sv
// Encode clock source and capture logic at the converter's far side.
// Assumes the bench gates run and resolves the floating output pins.
`timescale 1ns/100ps
module enc_source (
  input wire logic run,
  input wire logic syncPin,
  input wire adc_port_pkg::sample_t pinBus,
  output logic encClk,
  output adc_port_pkg::sample_t capSample,
  output logic capTgl,
  output int riseCount
);
  import adc_port_pkg::*;
  initial begin
    encClk = 1'b0;
    capTgl = 1'b0;
    riseCount = 0;
    #3.3;
    // Stands low between bursts; even 80 ns phases
    forever begin
      wait (run);
      #80 encClk = 1'b1;
      riseCount++;
      #80 encClk = 1'b0;
    end
  end
  // Timing taken from the output clock, never from encode
  always @(posedge syncPin) begin
    capSample = pinBus;
    capTgl = ~capTgl;
  end
endmodule : enc_source

// ### test/testbench.sv
// Self-checking bench for the converter output port.
// Assumes enc_source makes encode and captures the pins.
`timescale 1ns/100ps
module testbench;
  import adc_port_pkg::*;
  localparam int PIPE = 3;
  localparam logic signed [LEVEL_W-1:0] CORNER[4] = '{14'sh0bb8, FS_MAX, -14'sh0801, FS_MIN};
  logic sys_clk = 0, resetn = 0, fmtSel = 1, oeN = 1, run = 0;
  logic signed [LEVEL_W-1:0] level = '0;
  logic [WORD_W-1:0] word;
  logic flag, syncClk, drvEn, encClk, capTgl;
  sample_t capSample;
  int riseCount, capCount = 0, err_count = 0, checks = 0, seed = 32'h0272_defc, n = 0;
  logic signed [LEVEL_W-1:0] lvQ[$];
  wire sample_t pinBus = drvEn ? {flag, word} : 'z;
  // Pull-down on the released clock line; a float would fake a capture edge
  wire syncPin = drvEn ? syncClk : 1'b0;
  adc_encode_and_output_port #(.PIPE_DEPTH(PIPE)) dut_u (.sys_clk(sys_clk), .resetn(resetn),
    .encode_clock_in(encClk), .code_format_select(fmtSel), .outputEnable_n(oeN), .analogLevel(level),
    .dataWord_r(word), .range_exceed_flag_r(flag), .output_sync_clock_r(syncClk), .driveEnable_r(drvEn));
  enc_source src_u (.run(run), .syncPin(syncPin), .pinBus(pinBus), .encClk(encClk),
    .capSample(capSample), .capTgl(capTgl), .riseCount(riseCount));
  initial forever #4 sys_clk = ~sys_clk;
  function automatic sample_t expect_f(logic signed [LEVEL_W-1:0] lv, logic fmt);
    sample_t s;
    s.rangeExceed = lv > FS_MAX || lv < FS_MIN;
    s.code = s.rangeExceed ? (lv < 0 ? 12'h000 : 12'hfff) : lv[WORD_W-1:0] ^ OFFSET_MID;
    s.code[WORD_W-1] = s.code[WORD_W-1] ^ !fmt;
    return s;
  endfunction : expect_f
  task automatic check_sample(sample_t got, sample_t exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t sample %h expected %h", $time, got, exp);
    end
  endtask : check_sample
  task automatic check_bit(logic got, logic exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t bit %b expected %b", $time, got, exp);
    end
  endtask : check_bit
  task automatic complete_run;
    $display("Mismatches %0d of %0d comparisons", err_count, checks);
    if (err_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  always @(posedge encClk) begin
    lvQ.push_back(level);
    if (lvQ.size() > PIPE + 1) lvQ.pop_front();
  end
  // New level only after the hold edge has passed
  always @(negedge encClk) begin
    @(posedge sys_clk) #1;
    n++;
    level = (n % 4 == 0) ? CORNER[(n / 4) % 4] : LEVEL_W'($random(seed) % 2048);
  end
  // Ignores the toggle's first settling at time zero
  always @(capTgl) if (resetn) begin
    capCount++;
    if (lvQ.size() == PIPE + 1) check_sample(capSample, expect_f(lvQ[0], fmtSel));
    if ($random(seed) % 4 == 0) begin
      @(posedge sys_clk) #1;
      fmtSel = ~fmtSel;
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 resetn = 1;
    run = 1;
    repeat (40) @(capTgl);
    @(posedge sys_clk) #1 run = 0;
    // Enable moved only while encode stands still
    repeat (30) @(posedge sys_clk);
    #1 oeN = 0;
    repeat (4) @(posedge sys_clk);
    #1 check_bit(drvEn, 1'b0);
    oeN = 1;
    repeat (4) @(posedge sys_clk);
    #1 check_bit(drvEn, 1'b1);
    run = 1;
    repeat (30) @(capTgl);
    @(posedge sys_clk) #1 run = 0;
    repeat (30) @(posedge sys_clk);
    check_bit(logic'(riseCount == capCount), 1'b1);
    complete_run();
  end
  initial begin
    #50000;
    err_count++;
    complete_run();
  end
endmodule : testbench
